// [inc/acralu_defines.svh]
// Constants for the accumulator register ALU: fields, codes and reset values
`ifndef ACRALU_DEFINES_SVH
`define ACRALU_DEFINES_SVH

// Opcode fields
`define ACRALU_GROUP_MSB 7
`define ACRALU_GROUP_LSB 6
`define ACRALU_OP_MSB 5
`define ACRALU_OP_LSB 3
`define ACRALU_SRC_MSB 2
`define ACRALU_SRC_LSB 0

// Opcode group of the accumulator/register instructions
`define ACRALU_GROUP_ACC 2'h2

// Source select codes
`define ACRALU_SRC_ACC 3'h0
`define ACRALU_SRC_FIRST_SCRATCH 3'h1
`define ACRALU_SRC_LAST_SCRATCH 3'h6
`define ACRALU_SRC_MEM 3'h7

// Register and flag reset values
`define ACRALU_REG_RST 8'h00
`define ACRALU_FLAG_RST 1'h0

`endif

// [inc/acralu_pkg.sv]
// Types for the accumulator register ALU
package acralu_pkg;

  typedef logic [7:0] acralu_byte_t;

  typedef logic [2:0] acralu_sel_t;

  typedef enum logic [2:0] {
    ACRALU_OP_ADD = 3'h0,
    ACRALU_OP_ADC = 3'h1,
    ACRALU_OP_SUB = 3'h2,
    ACRALU_OP_SBB = 3'h3,
    ACRALU_OP_AND = 3'h4,
    ACRALU_OP_XOR = 3'h5,
    ACRALU_OP_OR = 3'h6,
    ACRALU_OP_CMP = 3'h7
  } acralu_op_e;

endpackage

// [verilog/acralu_core.sv]
// Accumulator ALU with scratchpad registers and condition flags
//
// Functional notes
// [RULE1] Carry set on carry or borrow, else cleared
// [RULE2] Zero flag set when result is zero
// [RULE3] Sign flag copies result bit 7
// [RULE4] Parity flag one for even ones count
// [RULE5] AND, XOR, OR always clear carry
// [RULE6] Rotate touches only the carry flag
// [RULE7] One-byte ops write only the accumulator
// [RULE8] 10 000 src adds source to accumulator
// [RULE9] 10 001 src adds source plus carry
// [RULE10] 10 010 src subtracts source, two's complement
// [RULE11] 10 011 src subtracts source and carry
// [RULE12] 10 100 src stores accumulator AND source
// [RULE13] 10 101 src stores accumulator XOR source
// [RULE14] 10 110 src stores accumulator OR source
// [RULE15] 10 111 src compares, accumulator unchanged
// [RULE16] Compare: carry if source exceeds, zero if equal
// [RULE17] Compare sets sign and parity like subtract
// [RULE18] Source 000 A, 001-110 B..L, 111 memory
// [RULE19] Unaffected flags hold their previous values
`timescale 1ns/1ns
`default_nettype none

`include "acralu_defines.svh"

module acralu_core #(
  parameter int DATA_W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Instruction from the decoder
  input wire logic instr_valid,
  input wire acralu_pkg::acralu_byte_t instr_opcode,
  // Memory operand for source code 111
  input wire acralu_pkg::acralu_byte_t mem_operand,
  // Carry result of a rotate done elsewhere
  input wire logic rotate_valid,
  input wire logic rotate_carry,
  // Register loads from the rest of the processor
  input wire logic load_valid,
  input wire acralu_pkg::acralu_sel_t load_sel,
  input wire acralu_pkg::acralu_byte_t load_data,
  // Register readout
  input wire acralu_pkg::acralu_sel_t read_sel,
  output logic [7:0] read_data_q,
  // Accumulator and condition flags
  output logic [7:0] acc_q,
  output logic carry_q,
  output logic zero_q,
  output logic sign_q,
  output logic parity_q,
  // Completion of an accumulator instruction
  output logic done_q
);
  import acralu_pkg::*;

  // The opcode map fixes the datapath at one byte
  generate
    if (DATA_W != 8) begin : g_width_check
      $error("acralu_core supports DATA_W of 8 only");
    end
  endgenerate

  // Decode assumes the three opcode fields tile the byte with no gap
  generate
    if ((`ACRALU_GROUP_MSB != 7) || (`ACRALU_GROUP_LSB != `ACRALU_OP_MSB + 1) ||
        (`ACRALU_OP_LSB != `ACRALU_SRC_MSB + 1) || (`ACRALU_SRC_LSB != 0)) begin : g_field_check
      $error("acralu_core opcode fields must tile one byte");
    end
  endgenerate

  // The scratchpad array spans codes one to six; the macros must agree
  generate
    if ((`ACRALU_SRC_FIRST_SCRATCH != 1) || (`ACRALU_SRC_LAST_SCRATCH != 6)) begin : g_scratch_check
      $error("acralu_core scratchpad codes must run from one to six");
    end
  endgenerate

  // Instruction decode
  logic is_acc_op;
  acralu_op_e op;
  acralu_sel_t src_sel;

  // Opcodes outside the group are ignored without any sign to the decoder
  assign is_acc_op = instr_valid &&
    (instr_opcode[`ACRALU_GROUP_MSB:`ACRALU_GROUP_LSB] == `ACRALU_GROUP_ACC);
  assign op = acralu_op_e'(instr_opcode[`ACRALU_OP_MSB:`ACRALU_OP_LSB]);
  assign src_sel = instr_opcode[`ACRALU_SRC_MSB:`ACRALU_SRC_LSB];

  // Scratchpad registers B..L, indexed by their source codes
  logic [7:0] scratch_q [1:6];
  logic [7:0] scratch_d [1:6];
  wire logic [7:0] src_hit [1:6];
  wire logic [7:0] read_hit [1:6];

  genvar gi;
  generate
    for (gi = 1; gi <= 6; gi++) begin : g_scratch
      always_comb begin
        scratch_d[gi] = scratch_q[gi];
        // Accumulator instructions never write a scratchpad register
        if (load_valid && (load_sel == acralu_sel_t'(gi))) begin // [RULE7]
          scratch_d[gi] = load_data;
        end
      end

      // Each entry offers its byte only when selected
      assign src_hit[gi] = (src_sel == acralu_sel_t'(gi)) ? scratch_q[gi] : 8'h00;
      assign read_hit[gi] = (read_sel == acralu_sel_t'(gi)) ? scratch_q[gi] : 8'h00;

      always_ff @(posedge clk) begin
        if (!rst_n) begin
          scratch_q[gi] <= `ACRALU_REG_RST;
        end else begin
          scratch_q[gi] <= scratch_d[gi];
        end
      end
    end
  endgenerate

  // Folding per-entry hits keeps codes 0 and 7 from indexing past the array
  logic [7:0] src_scratch;
  logic [7:0] read_scratch;

  always_comb begin
    src_scratch = 8'h00;
    read_scratch = 8'h00;
    for (int i = 1; i <= 6; i++) begin
      src_scratch = src_scratch | src_hit[i];
      read_scratch = read_scratch | read_hit[i];
    end
  end

  // Source operand select
  logic [7:0] src_val;

  always_comb begin
    src_val = acc_q;
    unique case (src_sel)
      `ACRALU_SRC_ACC: begin // [RULE18]
        src_val = acc_q;
      end
      `ACRALU_SRC_MEM: begin // [RULE18]
        src_val = mem_operand;
      end
      default: begin // [RULE18]
        src_val = src_scratch;
      end
    endcase
  end

  // Arithmetic and logic
  logic [8:0] alu_wide;
  logic [7:0] alu_res;
  logic alu_carry;
  logic alu_write;

  always_comb begin
    alu_wide = 9'h000;
    alu_write = 1'h1;
    unique case (op)
      ACRALU_OP_ADD: begin
        alu_wide = {1'h0, acc_q} + {1'h0, src_val}; // [RULE8]
      end
      ACRALU_OP_ADC: begin
        alu_wide = {1'h0, acc_q} + {1'h0, src_val} + {8'h00, carry_q}; // [RULE9]
      end
      ACRALU_OP_SUB: begin
        alu_wide = {1'h0, acc_q} - {1'h0, src_val}; // [RULE10]
      end
      ACRALU_OP_SBB: begin
        alu_wide = {1'h0, acc_q} - {1'h0, src_val} - {8'h00, carry_q}; // [RULE11]
      end
      ACRALU_OP_AND: begin
        alu_wide = {1'h0, acc_q & src_val}; // [RULE12] [RULE5]
      end
      ACRALU_OP_XOR: begin
        alu_wide = {1'h0, acc_q ^ src_val}; // [RULE13] [RULE5]
      end
      ACRALU_OP_OR: begin
        alu_wide = {1'h0, acc_q | src_val}; // [RULE14] [RULE5]
      end
      ACRALU_OP_CMP: begin
        // Bit 8 is the borrow, which is set exactly when source exceeds A
        alu_wide = {1'h0, acc_q} - {1'h0, src_val}; // [RULE16]
        alu_write = 1'h0; // [RULE15]
      end
    endcase
    alu_res = alu_wide[7:0];
    alu_carry = alu_wide[8]; // [RULE1]
  end

  // Per-bit chains for zero and parity; parity starts at one so a clear byte reads even
  wire logic [8:0] par_chain;
  wire logic [8:0] any_chain;

  assign par_chain[0] = 1'h1;
  assign any_chain[0] = 1'h0;

  generate
    for (gi = 0; gi < 8; gi++) begin : g_flag_bits
      assign par_chain[gi + 1] = par_chain[gi] ^ alu_res[gi];
      assign any_chain[gi + 1] = any_chain[gi] | alu_res[gi];
    end
  endgenerate

  // Accumulator and done
  logic [7:0] acc_d;
  logic done_d;

  always_comb begin
    acc_d = acc_q;
    done_d = 1'h0;
    // Plain loads into A lose to an accumulator instruction other than compare in the same cycle
    if (load_valid && (load_sel == `ACRALU_SRC_ACC)) begin
      acc_d = load_data;
    end
    if (is_acc_op) begin
      if (alu_write) begin
        acc_d = alu_res; // [RULE7]
      end
      done_d = 1'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      acc_q <= `ACRALU_REG_RST;
      done_q <= 1'h0;
    end else begin
      acc_q <= acc_d;
      done_q <= done_d;
    end
  end

  // Condition flags; loads never touch them
  logic carry_d;
  logic zero_d;
  logic sign_d;
  logic parity_d;

  always_comb begin
    carry_d = carry_q; // [RULE19]
    zero_d = zero_q;
    sign_d = sign_q;
    parity_d = parity_q;
    if (is_acc_op) begin
      carry_d = alu_carry; // [RULE1] [RULE16]
      zero_d = ~any_chain[8]; // [RULE2] [RULE16]
      sign_d = alu_res[7]; // [RULE3] [RULE17]
      parity_d = par_chain[8]; // [RULE4] [RULE17]
    end else if (rotate_valid) begin
      // Zero, sign and parity keep their values across a rotate
      carry_d = rotate_carry; // [RULE6]
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      carry_q <= `ACRALU_FLAG_RST;
      zero_q <= `ACRALU_FLAG_RST;
      sign_q <= `ACRALU_FLAG_RST;
      parity_q <= `ACRALU_FLAG_RST;
    end else begin
      carry_q <= carry_d;
      zero_q <= zero_d;
      sign_q <= sign_d;
      parity_q <= parity_d;
    end
  end

  // Registered readout; shows state after the previous edge
  logic [7:0] read_data_d;

  always_comb begin
    read_data_d = acc_q;
    unique case (read_sel)
      `ACRALU_SRC_ACC: begin
        read_data_d = acc_q;
      end
      `ACRALU_SRC_MEM: begin
        // Memory lives outside; read back the operand pins
        read_data_d = mem_operand;
      end
      default: begin
        read_data_d = read_scratch;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      read_data_q <= `ACRALU_REG_RST;
    end else begin
      read_data_q <= read_data_d;
    end
  end

endmodule

`default_nettype wire

// [tb/acralu_properties.sv]
// Concurrent checks on the accumulator ALU ports
`timescale 1ns/1ns
`default_nettype none
module acralu_properties (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Watched ports
  input wire logic instr_valid,
  input wire acralu_pkg::acralu_byte_t instr_opcode,
  input wire logic rotate_valid,
  input wire logic rotate_carry,
  input wire logic load_valid,
  input wire logic [7:0] acc_q,
  input wire logic carry_q,
  input wire logic zero_q,
  input wire logic sign_q,
  input wire logic parity_q,
  input wire logic done_q
);
  import acralu_pkg::*;
  wire logic g = instr_valid && instr_opcode[7:6] == 2'h2;
  wire logic [2:0] op = instr_opcode[5:3];
  // Compare leaves acc alone, so flag checks against acc skip it
  wire logic ar = g && op != 3'h7;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_done_pulse: assert property (g |=> done_q)
    else $error("done missing");
  chk_logic_carry: assert property (g && op inside {[4:6]} |=> !carry_q)
    else $error("logic carry set");
  chk_sign_bit: assert property (ar |=> sign_q == acc_q[7])
    else $error("sign wrong");
  chk_parity_even: assert property (ar |=> parity_q == ~^acc_q)
    else $error("parity wrong");
  chk_zero_flag: assert property (ar |=> zero_q == (acc_q == 8'h00))
    else $error("zero wrong");
  chk_cmp_keep: assert property (g && op == 3'h7 && !load_valid |=> $stable(acc_q))
    else $error("compare wrote acc");
  chk_rot_carry: assert property (rotate_valid && !g |=> carry_q == $past(rotate_carry) &&
    $stable({zero_q, sign_q, parity_q}))
    else $error("rotate flags wrong");
  chk_flag_hold: assert property (!g && !rotate_valid |=> $stable({carry_q, zero_q, sign_q, parity_q}))
    else $error("flags moved");
  chk_add_double: assert property (instr_valid && instr_opcode == 8'h80 |=>
    acc_q == {$past(acc_q[6:0]), 1'h0} && carry_q == $past(acc_q[7]))
    else $error("add self wrong");
  cover property (g && op == 3'h1);
  cover property (g && op == 3'h7);
  cover property (rotate_valid);
endmodule
bind acralu_core acralu_properties chk_u (.clk, .rst_n, .instr_valid, .instr_opcode, .rotate_valid, .rotate_carry,
  .load_valid, .acc_q, .carry_q, .zero_q, .sign_q, .parity_q, .done_q);
`default_nettype wire

// [tb/acralu_mem_model.sv]
// Memory byte model feeding the operand for source code 111
`timescale 1ns/1ns
`default_nettype none
module acralu_mem_model (
  // Clock
  input wire logic clk,
  // Stored byte and operand seen by the ALU
  input wire acralu_pkg::acralu_byte_t wr_data,
  output var acralu_pkg::acralu_byte_t mem_operand
);
  import acralu_pkg::*;
  // A read lands a cycle after the byte is written, like a real memory
  always_ff @(posedge clk) mem_operand <= wr_data;
endmodule
`default_nettype wire

// [tb/accumulator_register_alu_bench.sv]
// Self-checking bench for the accumulator ALU
`timescale 1ns/1ns
`default_nettype none
module accumulator_register_alu_bench;
  import acralu_pkg::*;
  logic clk = 1'h0, rst_n = 1'h0, iv = 1'h0, rv = 1'h0, rc = 1'h0, lv = 1'h0;
  acralu_byte_t op = 8'h00, ld = 8'h00, wd = 8'h00, mo, ea = 8'h00;
  acralu_sel_t ls = 3'h0, rs = 3'h0;
  logic [7:0] rd, acc;
  logic c, z, s, p, dn;
  logic [3:0] ef = 4'h0;
  int failures = 0, num_checks = 0;
  acralu_core dut_u (.clk, .rst_n, .instr_valid(iv), .instr_opcode(op), .mem_operand(mo), .rotate_valid(rv),
    .rotate_carry(rc), .load_valid(lv), .load_sel(ls), .load_data(ld), .read_sel(rs), .read_data_q(rd),
    .acc_q(acc), .carry_q(c), .zero_q(z), .sign_q(s), .parity_q(p), .done_q(dn));
  acralu_mem_model mem_u (.clk, .wr_data(wd), .mem_operand(mo));
  initial forever #50 clk = ~clk;
  task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  task automatic load(input logic [2:0] sl, input logic [7:0] d);
    lv = 1'h1;
    ls = sl;
    ld = d;
    tick;
    lv = 1'h0;
    // One idle edge so back-to-back loads never lower and raise the strobe at once
    tick;
  endtask
  function automatic logic [8:0] alu(input logic [2:0] o, input logic [7:0] a, input logic [7:0] b, input logic ci);
    case (o)
      3'h0: return a + b;
      3'h1: return a + b + ci;
      3'h2, 3'h7: return a - b;
      3'h3: return a - b - ci;
      3'h4: return {1'b0, a & b};
      3'h5: return {1'b0, a ^ b};
      default: return {1'b0, a | b};
    endcase
  endfunction
  task automatic do_op(input logic [2:0] o, input logic [2:0] sl, input logic [7:0] b);
    logic [8:0] r;
    r = alu(o, ea, b, ef[3]);
    iv = 1'h1;
    op = {2'h2, o, sl};
    tick;
    iv = 1'h0;
    ef = {r[8], r[7:0] == 8'h00, r[7], ~^r[7:0]};
    if (o != 3'h7) ea = r[7:0];
    cmp("acc", ea, acc);
    cmp("flags", {4'h0, ef}, {4'h0, c, z, s, p});
    cmp("done", 8'h01, {7'h00, dn});
    tick;
    cmp("done_end", 8'h00, {7'h00, dn});
  endtask
  task automatic t_ops;
    cmp("acc", 8'h00, acc);
    load(3'h1, 8'hC5);
    for (int i = 0; i < 8; i++) begin
      do_op(3'(i), 3'h1, 8'hC5);
    end
    do_op(3'h0, 3'h0, ea);
    load(3'h1, 8'hF0);
    do_op(3'h7, 3'h1, 8'hF0);
    do_op(3'h0, 3'h1, 8'hF0);
    do_op(3'h1, 3'h1, 8'hF0);
    do_op(3'h3, 3'h1, 8'hF0);
    rs = 3'h1;
    tick;
    cmp("src", 8'hF0, rd);
  endtask
  task automatic t_sel;
    for (int i = 1; i < 7; i++) load(3'(i), 8'(i * 17 + 3));
    wd = 8'h5A;
    tick;
    for (int i = 0; i < 8; i++) do_op(3'h6, 3'(i), i == 0 ? ea : i == 7 ? 8'h5A : 8'(i * 17 + 3));
  endtask
  task automatic t_rot;
    rv = 1'h1;
    rc = ~ef[3];
    tick;
    rv = 1'h0;
    ef[3] = rc;
    cmp("rot", {4'h0, ef}, {4'h0, c, z, s, p});
    iv = 1'h1;
    op = 8'hC1;
    tick;
    iv = 1'h0;
    tick;
    cmp("skip", {ea[3:0], ef}, {acc[3:0], c, z, s, p});
    cmp("idle", 8'h00, {7'h00, dn});
  endtask
  task automatic stop_test;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #100000;
    failures++;
    stop_test;
  end
  initial begin
    repeat (12) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_ops;
    t_sel;
    t_rot;
    stop_test;
  end
endmodule
`default_nettype wire
